// ### src/sad_pkg.sv
package sad_pkg;
    localparam int RESULT_W        = 12;
    localparam int HI_POS          = 8;
    localparam int NIB_W           = 4;
    localparam int CLK_PERIOD_PS   = 25000;
    localparam int ACCESS_NS       = 90;
    localparam int ACCESS_CYC      = (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RD_GAP_NS       = 40;
    localparam int RD_GAP_CYC      = (RD_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DATA_SETUP_NS   = 70;
    localparam int DATA_SETUP_CYC  = (DATA_SETUP_NS * 1000) / CLK_PERIOD_PS;
    localparam int CONV_NS         = 2700;
    localparam int CONV_CYC        = (CONV_NS * 1000) / CLK_PERIOD_PS;
    localparam int CNT_W           = 8;
    localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

    // Byte-mode pattern: top nibble repeated, middle nibble low
    function automatic logic [RESULT_W-1:0] sad_bus_word(input logic [RESULT_W-1:0] r, input logic hi);
        if (hi)
            return {r[RESULT_W-1 -: NIB_W], {NIB_W{1'b0}}, r[RESULT_W-1 -: NIB_W]};
        else
            return r;
    endfunction
endpackage

// ### src/sad_if.sv
`timescale 1ns/1ps
interface sad_if;
    import sad_pkg::*;
    logic                chip_sel_n;
    logic                read_n;
    logic                high_byte_select;
    logic                busy_n;
    logic [RESULT_W-1:0] data_out;
    logic [RESULT_W-1:0] data_oe_n;
    logic [RESULT_W-1:0] data_bus;

    // Resolved bus level; undriven pins read low here
    assign data_bus = data_out & ~data_oe_n;

    modport dev  (input chip_sel_n, read_n, high_byte_select, output busy_n, data_out, data_oe_n);
    modport host (output chip_sel_n, read_n, high_byte_select, input busy_n, data_bus);
endinterface

// ### src/sad_device.sv
`timescale 1ns/1ps
module sad_device
    import sad_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    // Clock and reset
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    // Analog stand-in
    input  wire logic [RESULT_W-1:0] sample_in,
    // Pins
    sad_if.dev                       pins
);
    typedef enum logic [0:0] {
        SAD_IDLE = 1'b0,
        SAD_CONV = 1'b1
    } sad_state_t;

    sad_state_t          state_reg, state_next;
    logic [CNT_W-1:0]    cnt_reg, cnt_next;
    logic [RESULT_W-1:0] approx_reg, approx_next;
    logic [RESULT_W-1:0] latch_reg, latch_next;
    logic [RESULT_W-1:0] dout_reg, dout_next;
    logic [RESULT_W-1:0] oe_n_reg, oe_n_next;
    logic                busy_n_reg, busy_n_next;
    logic                rd_d_reg, rd_d_next;
    logic                start;
    logic                drive;

    // Qualified falling strobe; high byte read never starts
    assign start = rd_d_reg & ~pins.read_n & ~pins.chip_sel_n & ~pins.high_byte_select;
    assign drive = ~pins.read_n & ~pins.chip_sel_n;

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        approx_next = approx_reg;
        latch_next  = latch_reg;
        busy_n_next = busy_n_reg;
        rd_d_next   = pins.read_n;
        case (state_reg)
            SAD_IDLE: begin
                if (start) begin
                    state_next  = SAD_CONV;
                    approx_next = '0;
                    cnt_next    = CNT_W'(CONV_CYCLES - 1);
                    busy_n_next = 1'b0;
                end
            end
            SAD_CONV: begin
                // Further starts ignored here
                if (cnt_reg == '0) begin
                    state_next  = SAD_IDLE;
                    busy_n_next = 1'b1;
                    latch_next  = approx_reg;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                    // Stand-in successive approximation, MSB first
                    if (cnt_reg <= CNT_W'(RESULT_W))
                        approx_next[cnt_reg[3:0] - 4'h1] = sample_in[cnt_reg[3:0] - 4'h1];
                end
            end
            default: begin
                state_next  = SAD_IDLE;
                busy_n_next = 1'b1;
            end
        endcase
    end

    // Latch updates with busy rising, so data is ready in the same cycle
    always_comb begin
        dout_next = sad_bus_word(latch_next, pins.high_byte_select);
        oe_n_next = drive ? '0 : '1;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg  <= SAD_IDLE;
            cnt_reg    <= '0;
            approx_reg <= RESULT_RST;
            latch_reg  <= RESULT_RST;
            dout_reg   <= RESULT_RST;
            oe_n_reg   <= '1;
            busy_n_reg <= 1'b1;
            rd_d_reg   <= 1'b1;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            approx_reg <= approx_next;
            latch_reg  <= latch_next;
            dout_reg   <= dout_next;
            oe_n_reg   <= oe_n_next;
            busy_n_reg <= busy_n_next;
            rd_d_reg   <= rd_d_next;
        end
    end

    assign pins.busy_n    = busy_n_reg;
    assign pins.data_out  = dout_reg;
    assign pins.data_oe_n = oe_n_reg;
endmodule

// ### src/sad_host.sv
`timescale 1ns/1ps
module sad_host
    import sad_pkg::*;
#(
    parameter int ACC_CYCLES = ACCESS_CYC,
    parameter int GAP_CYCLES = RD_GAP_CYC
) (
    // Clock and reset
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    // User requests
    input  wire logic                req_in,
    input  wire logic                byte_mode_in,
    output logic                     ready_out,
    output logic                     done_out,
    output logic [RESULT_W-1:0]      result_out,
    // Pins
    sad_if.host                      pins
);
    typedef enum logic [2:0] {
        SH_IDLE  = 3'b000,
        SH_START = 3'b001,
        SH_WAIT  = 3'b010,
        SH_RDLO  = 3'b011,
        SH_GAP   = 3'b100,
        SH_RDHI  = 3'b101,
        SH_END   = 3'b110
    } sh_state_t;

    sh_state_t           state_reg, state_next;
    logic [CNT_W-1:0]    cnt_reg, cnt_next;
    logic                cs_n_reg, cs_n_next;
    logic                rd_n_reg, rd_n_next;
    logic                hb_reg, hb_next;
    logic                bm_reg, bm_next;
    logic                done_reg, done_next;
    logic                ready_reg, ready_next;
    logic [RESULT_W-1:0] res_reg, res_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        cs_n_next  = cs_n_reg;
        rd_n_next  = rd_n_reg;
        hb_next    = hb_reg;
        bm_next    = bm_reg;
        done_next  = 1'b0;
        ready_next = 1'b0;
        res_next   = res_reg;
        if (cnt_reg != '0)
            cnt_next = cnt_reg - 1'b1;
        case (state_reg)
            SH_IDLE: begin
                // A low-byte read starts a conversion, so wait until it is over
                ready_next = pins.busy_n;
                if (req_in & ready_reg & pins.busy_n) begin
                    ready_next = 1'b0;
                    bm_next    = byte_mode_in;
                    cs_n_next  = 1'b0;
                    rd_n_next  = 1'b0;
                    hb_next    = 1'b0;
                    cnt_next   = CNT_W'(ACC_CYCLES);
                    state_next = SH_START;
                end
            end
            SH_START: if (cnt_reg == '0) begin
                rd_n_next  = 1'b1;
                cnt_next   = CNT_W'(GAP_CYCLES);
                state_next = SH_WAIT;
            end
            SH_WAIT: if (cnt_reg == '0 && pins.busy_n) begin
                // Busy sampled only after strobe gap; it is still low then, so wait for it to go high
                // Byte mode reads the high byte first, while the converter is idle
                hb_next    = bm_reg;
                rd_n_next  = 1'b0;
                cnt_next   = CNT_W'(ACC_CYCLES);
                state_next = SH_RDLO;
            end
            SH_RDLO: if (cnt_reg == '0) begin
                rd_n_next  = 1'b1;
                res_next   = bm_reg ? {pins.data_bus[NIB_W-1:0], {HI_POS{1'b0}}} : pins.data_bus;
                cnt_next   = CNT_W'(GAP_CYCLES);
                state_next = bm_reg ? SH_GAP : SH_END;
            end
            SH_GAP: if (cnt_reg == '0) begin
                hb_next    = 1'b0;
                rd_n_next  = 1'b0;
                cnt_next   = CNT_W'(ACC_CYCLES);
                state_next = SH_RDHI;
            end
            SH_RDHI: if (cnt_reg == '0) begin
                rd_n_next  = 1'b1;
                res_next   = {res_reg[RESULT_W-1 -: NIB_W], pins.data_bus[HI_POS-1:0]};
                cnt_next   = CNT_W'(GAP_CYCLES);
                state_next = SH_END;
            end
            SH_END: if (cnt_reg == '0 && rd_n_reg) begin
                hb_next    = 1'b0;
                cs_n_next  = 1'b1;
                done_next  = 1'b1;
                state_next = SH_IDLE;
            end
            default: state_next = SH_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg <= SH_IDLE;
            cnt_reg   <= '0;
            cs_n_reg  <= 1'b1;
            rd_n_reg  <= 1'b1;
            hb_reg    <= 1'b0;
            bm_reg    <= 1'b0;
            done_reg  <= 1'b0;
            ready_reg <= 1'b0;
            res_reg   <= RESULT_RST;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            cs_n_reg  <= cs_n_next;
            rd_n_reg  <= rd_n_next;
            hb_reg    <= hb_next;
            bm_reg    <= bm_next;
            done_reg  <= done_next;
            ready_reg <= ready_next;
            res_reg   <= res_next;
        end
    end

    assign pins.chip_sel_n       = cs_n_reg;
    assign pins.read_n           = rd_n_reg;
    assign pins.high_byte_select = hb_reg;
    assign ready_out             = ready_reg;
    assign done_out              = done_reg;
    assign result_out            = res_reg;
endmodule

// ### verification/sad_chk.sv
`timescale 1ns/1ps
module sad_chk
    import sad_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC
) (
    // Clock and reset
    input wire logic                ref_clk_in,
    input wire logic                rst_in,
    // Pins
    input wire logic                chip_sel_n,
    input wire logic                read_n,
    input wire logic                high_byte_select,
    input wire logic                busy_n,
    input wire logic [RESULT_W-1:0] data_out,
    input wire logic [RESULT_W-1:0] data_oe_n
);
    logic [CNT_W-1:0] low_cnt_reg;
    logic [CNT_W-1:0] low_cnt_next;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // Busy-low length in cycles, cleared whenever idle
    always_comb begin
        low_cnt_next = busy_n ? '0 : low_cnt_reg + 1'b1;
    end
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in)
            low_cnt_reg <= '0;
        else
            low_cnt_reg <= low_cnt_next;
    end

    property p_start;
        $fell(read_n) && !chip_sel_n && !high_byte_select && busy_n |=> !busy_n;
    endproperty
    property p_hbs_block;
        $fell(read_n) && high_byte_select && busy_n |=> busy_n;
    endproperty
    property p_cs_ignore;
        chip_sel_n && busy_n |=> busy_n;
    endproperty
    property p_oe_off;
        read_n || chip_sel_n |=> data_oe_n == '1;
    endproperty
    property p_oe_on;
        !read_n && !chip_sel_n |=> data_oe_n == '0;
    endproperty
    property p_conv_len;
        $rose(busy_n) |-> low_cnt_reg == CNT_W'(CONV_CYCLES);
    endproperty
    property p_no_restart;
        low_cnt_reg <= CNT_W'(CONV_CYCLES);
    endproperty
    property p_hbs_pat;
        data_oe_n == '0 && $past(data_oe_n) == '0 && $past(high_byte_select)
            |-> data_out[7:4] == 4'h0 && data_out[3:0] == data_out[11:8];
    endproperty
    // Latch only moves when busy rises
    property p_hold;
        busy_n && $past(busy_n) && data_oe_n == '0 && $past(data_oe_n) == '0
            && $past(high_byte_select) == $past(high_byte_select, 2) |-> $stable(data_out);
    endproperty

    a_start: assert property (p_start) else $error("start not taken");
    a_hbs_block: assert property (p_hbs_block) else $error("start with high byte select");
    a_cs_ignore: assert property (p_cs_ignore) else $error("start without chip select");
    a_oe_off: assert property (p_oe_off) else $error("pins driven while deselected");
    a_oe_on: assert property (p_oe_on) else $error("pins not driven during read");
    a_conv_len: assert property (p_conv_len) else $error("busy length wrong");
    a_no_restart: assert property (p_no_restart) else $error("conversion restarted");
    a_hbs_pat: assert property (p_hbs_pat) else $error("byte pattern wrong");
    a_hold: assert property (p_hold) else $error("output latch moved");

    c_start: cover property ($fell(busy_n));
    c_hbs_read: cover property (data_oe_n == '0 && high_byte_select);
    c_done: cover property ($rose(busy_n));
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
    import sad_pkg::*;
    localparam int CONV_SIM = 20;
    logic                ref_clk_in   = 1'b0;
    logic                rst_in       = 1'b1;
    logic                req_in       = 1'b0;
    logic                byte_mode_in = 1'b0;
    logic [RESULT_W-1:0] sample_in    = 12'h000;
    logic                ready_out;
    logic                done_out;
    logic [RESULT_W-1:0] result_out;
    logic [RESULT_W-1:0] lat_exp      = 12'h000;
    logic                hb_d         = 1'b0;
    logic                busy_d       = 1'b1;
    logic [RESULT_W-1:0] corner [6]   = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h001, 12'ha5c};
    int                  n_errors     = 0;
    int                  tests_run    = 0;

    sad_if ifc();
    sad_device #(.CONV_CYCLES(CONV_SIM)) i_sad_device (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .sample_in(sample_in), .pins(ifc));
    sad_host i_sad_host (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .req_in(req_in), .byte_mode_in(byte_mode_in),
        .ready_out(ready_out), .done_out(done_out), .result_out(result_out), .pins(ifc));
    sad_chk #(.CONV_CYCLES(CONV_SIM)) i_sad_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .chip_sel_n(ifc.chip_sel_n), .read_n(ifc.read_n), .high_byte_select(ifc.high_byte_select),
        .busy_n(ifc.busy_n), .data_out(ifc.data_out), .data_oe_n(ifc.data_oe_n));

    always #12.5 ref_clk_in = ~ref_clk_in;

    function automatic logic [RESULT_W-1:0] pins_exp(input logic [RESULT_W-1:0] v, input logic h);
        return h ? {v[11:8], 4'h0, v[11:8]} : v;
    endfunction

    task automatic check_word(input logic [RESULT_W-1:0] got, input logic [RESULT_W-1:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic give_verdict;
        if (n_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Sample only changes while the converter is idle, like a held analog input
    task automatic convert(input logic [RESULT_W-1:0] v, input logic m);
        int k;
        k = 0;
        while (ready_out !== 1'b1 && k < 500) begin
            @(negedge ref_clk_in);
            k++;
        end
        @(posedge ref_clk_in);
        sample_in    <= v;
        byte_mode_in <= m;
        req_in       <= 1'b1;
        @(posedge ref_clk_in);
        req_in <= 1'b0;
        k = 0;
        do begin
            @(negedge ref_clk_in);
            k++;
        end while (done_out !== 1'b1 && k < 1000);
        check_word({11'h000, done_out}, 12'h001, "done");
        check_word(result_out, v, "result");
    endtask

    // Pin watcher: data follows byte select with one cycle lag
    always @(negedge ref_clk_in) begin
        if (ifc.busy_n === 1'b1 && busy_d === 1'b0)
            lat_exp = sample_in;
        busy_d = ifc.busy_n;
        if (ifc.busy_n === 1'b1 && ifc.data_oe_n === 12'h000 && hb_d === ifc.high_byte_select)
            check_word(ifc.data_bus, pins_exp(lat_exp, hb_d), "bus");
        hb_d = ifc.high_byte_select;
    end

    initial begin
        void'($urandom(43));
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            convert(corner[i], 1'b0);
            convert(corner[i], 1'b1);
        end
        repeat (12) convert(12'($urandom()), 1'($urandom()));
        give_verdict();
    end

    initial begin
        #(25 * 20000);
        n_errors++;
        $display("[ERR] %0t timeout", $time);
        give_verdict();
    end
endmodule
